/* gauge_target.sv */
// Overview of operation
// - answer only target address 1010101
// - three read and write forms
// - quick read returns byte at pointer
// - pointer advances on every acknowledged data byte
// - data to read-only location is nacked
// - command byte above 0x6B is nacked
// - release lines after units times 0.5 s low
// - still low after release: enter sleep
// - host waits 100 ms after checksum
// - host waits 1.2 s after measurement
// - host waits 2 s after read-write command
// - host polls full set at most twice/second
// - store updates stretch up to 80 ms
// - measurement stretch up to 270 ms
// - deep sleep, hibernate: stretch every transaction
// - wake setting 0x09 gives 32 us, else 4 ms
// - normal, light sleep: stretch own packets only
// - stretch after start, ack; routine up to 4 ms
// - table update stretch up to 24 ms
// - block write stretch up to 72 ms
// - restore stretch up to 116 ms
// - status 0x6A bit 0 shows last profile
//
// The APB interface to the registers was chosen for this implementation.
module gauge_target
  import gauge_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF,
  parameter int CYC_PER_US = CYC_PER_US_DEF
)
(
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  gauge_link_if.device          link,
  input  wire power_mode_type   power_mode_i,
  input  wire logic [7:0]       wake_setting_i,
  input  wire logic             store_busy_i,
  input  wire stretch_kind_type store_kind_i,
  input  wire logic [7:0]       timeout_units_i,
  output logic                  last_profile_o,
  output logic                  bus_sleep_o
);
  typedef enum logic [2:0] {st_idle, st_addr, st_cmd, st_wdata, st_rdata,
                            st_skip} phase_type;

  phase_type   st;
  logic        scl_m;
  logic        scl_s;
  logic        scl_q;
  logic        sda_m;
  logic        sda_s;
  logic        sda_q;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic [7:0]  ptr;
  logic        scl_oe;
  logic        sda_oe;
  logic        wake_pend;
  logic        store_hold;
  logic [31:0] stretch_cnt;
  logic [31:0] low_cnt;
  logic [7:0]  units;
  logic        released;
  logic [7:0]  mem [0:MEM_WORDS-1];

  function automatic int cap_cycles(input stretch_kind_type k);
    unique case (k)
      k_routine: return ms_cycles(ROUTINE_MS, CYC_PER_MS);
      k_table:   return ms_cycles(TABLE_MS, CYC_PER_MS);
      k_block:   return ms_cycles(BLOCK_MS, CYC_PER_MS);
      k_restore: return ms_cycles(RESTORE_MS, CYC_PER_MS);
      k_store:   return ms_cycles(STORE_MS, CYC_PER_MS);
      k_measure: return ms_cycles(MEASURE_MS, CYC_PER_MS);
      default:   return ms_cycles(ROUTINE_MS, CYC_PER_MS);
    endcase
  endfunction

  function automatic logic read_only(input logic [7:0] a);
    return (a >= RO_FIRST && a <= RO_LAST) || a == PROFILE_STATUS_CMD
           || a > CMD_LAST;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire scl_rise  = scl_s && !scl_q;
  wire scl_fall  = !scl_s && scl_q;
  wire start_seen = scl_s && scl_q && sda_q && !sda_s;
  wire stop_seen  = scl_s && scl_q && !sda_q && sda_s;
  wire bus_low   = !scl_s || !sda_s;
  wire deep      = power_mode_i == pm_deep_sleep_state
                   || power_mode_i == pm_hibernate;
  wire addr_hit  = shreg[7:1] == TARGET_ADDR;
  wire cmd_ok    = shreg <= CMD_LAST;
  wire wr_ok     = !read_only(ptr);
  wire in_space  = ptr < 8'(MEM_WORDS);
  wire [7:0] rd_byte = (ptr == PROFILE_STATUS_CMD) ? {7'h00, last_profile_o}
                       : in_space ? mem[ptr[6:0]] : 8'h00;
  wire ack_now   = (st == st_addr && addr_hit) || (st == st_cmd && cmd_ok)
                   || (st == st_wdata && wr_ok);
  wire edge_ok   = !released && !start_seen && !stop_seen;
  wire byte_end  = edge_ok && scl_fall && bitcnt == 4'd8;
  wire ack_end   = edge_ok && scl_fall && bitcnt == 4'd9;
  wire mem_we    = byte_end && st == st_wdata && wr_ok && in_space;
  wire [31:0] wake_cyc = (wake_setting_i == WAKE_FAST_SET)
                         ? 32'(WAKE_FAST_US * CYC_PER_US)
                         : 32'(ms_cycles(WAKE_SLOW_MS, CYC_PER_MS));
  wire [31:0] unit_cyc = 32'(ms_cycles(TIMEOUT_UNIT_MS, CYC_PER_MS));
  wire stretch_done = stretch_cnt == 32'h0
                      || (store_hold && !store_busy_i);

  assign link.scl_dev_o  = 1'b0;
  assign link.sda_dev_o  = 1'b0;
  assign link.scl_dev_oe = scl_oe;
  assign link.sda_dev_oe = sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_sys_i)
  begin
    scl_m <= link.scl;
    sda_m <= link.sda;
    scl_s <= scl_m;
    sda_s <= sda_m;
    scl_q <= scl_s;
    sda_q <= sda_s;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (mem_we)
      mem[ptr[6:0]] <= shreg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stuck-bus timeout
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || !bus_low)
    begin
      low_cnt     <= 32'h0;
      units       <= 8'h00;
      released    <= 1'b0;
      bus_sleep_o <= 1'b0;
    end
    else if (released)
    begin
      if (low_cnt == 32'(SETTLE_CYC))
        bus_sleep_o <= 1'b1;
      else
        low_cnt <= low_cnt + 32'h1;
    end
    else if (low_cnt == unit_cyc - 32'h1)
    begin
      low_cnt <= 32'h0;
      units   <= units + 8'h01;
      if (timeout_units_i != 8'h00 && units + 8'h01 >= timeout_units_i)
        released <= 1'b1;
    end
    else
      low_cnt <= low_cnt + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      st <= st_idle;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      wake_pend <= 1'b0;
      store_hold <= 1'b0;
      stretch_cnt <= 32'h0;
      last_profile_o <= 1'b0;
    end
    else if (released)
    begin
      st     <= st_idle;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_seen)
    begin
      st        <= st_addr;
      bitcnt    <= 4'h0;
      sda_oe    <= 1'b0;
      wake_pend <= deep;
    end
    else if (stop_seen)
    begin
      st     <= st_idle;
      sda_oe <= 1'b0;
    end
    else
    begin
      if (scl_oe)
      begin
        if (stretch_done)
          scl_oe <= 1'b0;
        else
          stretch_cnt <= stretch_cnt - 32'h1;
      end
      if (st != st_idle && scl_rise)
      begin
        if (bitcnt < 4'd8)
        begin
          shreg  <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'd1;
        end
        else if (bitcnt == 4'd9 && st == st_rdata && !sda_oe)
        begin
          if (sda_s)
            st <= st_skip;
          else
            ptr <= ptr + 8'h01;
        end
      end
      if (st != st_idle && scl_fall)
      begin
        if (wake_pend)
        begin
          wake_pend   <= 1'b0;
          scl_oe      <= 1'b1;
          store_hold  <= 1'b0;
          stretch_cnt <= wake_cyc;
        end
        if (bitcnt >= 4'd1 && bitcnt <= 4'd7 && st == st_rdata)
        begin
          tx     <= {tx[6:0], 1'b0};
          sda_oe <= !tx[6];
        end
        else if (byte_end)
        begin
          bitcnt <= 4'd9;
          sda_oe <= ack_now;
          unique case (st)
            st_addr:
              st <= !addr_hit ? st_skip
                    : shreg[0] ? st_rdata : st_cmd;
            st_cmd:
              if (cmd_ok)
              begin
                ptr <= shreg;
                st  <= st_wdata;
              end
              else
                st <= st_skip;
            st_wdata:
              if (wr_ok)
              begin
                ptr <= ptr + 8'h01;
                if (ptr == CTRL_LO_CMD && shreg == PICK_A_CODE)
                  last_profile_o <= 1'b0;
                if (ptr == CTRL_LO_CMD && shreg == PICK_B_CODE)
                  last_profile_o <= 1'b1;
              end
              else
                st <= st_skip;
            st_rdata: sda_oe <= 1'b0;
            st_skip:  sda_oe <= 1'b0;
            st_idle:  sda_oe <= 1'b0;
          endcase
        end
        else if (ack_end)
        begin
          bitcnt <= 4'h0;
          if (st == st_rdata)
          begin
            tx     <= rd_byte;
            sda_oe <= !rd_byte[7];
          end
          else
            sda_oe <= 1'b0;
          if (st != st_skip && store_busy_i && !wake_pend)
          begin
            scl_oe      <= 1'b1;
            store_hold  <= 1'b1;
            stretch_cnt <= 32'(cap_cycles(store_kind_i));
          end
        end
      end
    end
  end
endmodule

/* gauge_pkg.sv */
package gauge_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // link addressing and command space
  localparam logic [6:0] TARGET_ADDR        = 7'h55;
  localparam logic [7:0] CMD_LAST           = 8'h6B;
  localparam logic [7:0] PROFILE_STATUS_CMD = 8'h6A;
  localparam logic [7:0] CTRL_LO_CMD        = 8'h00;
  localparam logic [7:0] RO_FIRST           = 8'h02;
  localparam logic [7:0] RO_LAST            = 8'h3F;
  localparam logic [7:0] PICK_A_CODE        = 8'h0A;
  localparam logic [7:0] PICK_B_CODE        = 8'h0B;
  localparam logic [7:0] WAKE_FAST_SET      = 8'h09;
  localparam logic [7:0] WAKE_SLOW_SET      = 8'h00;
  localparam int         MEM_WORDS          = 108;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS          = 5;
  localparam int CYC_PER_US_DEF  = 1000 / CLK_NS;
  localparam int CYC_PER_MS_DEF  = 1000 * CYC_PER_US_DEF;
  localparam int LINK_PERIOD_NS  = 80;
  localparam int QUARTER_CYC     = LINK_PERIOD_NS / CLK_NS / 4;
  localparam int SETTLE_CYC      = 8;
  localparam int TIMEOUT_UNIT_MS = 500;
  localparam int WAKE_FAST_US    = 32;
  localparam int WAKE_SLOW_MS    = 4;
  localparam int ROUTINE_MS      = 4;
  localparam int TABLE_MS        = 24;
  localparam int BLOCK_MS        = 72;
  localparam int RESTORE_MS      = 116;
  localparam int STORE_MS        = 80;
  localparam int MEASURE_MS      = 270;
  localparam int WAIT_SUM_MS     = 100;
  localparam int WAIT_MEASURE_MS = 1200;
  localparam int WAIT_RW_MS      = 2000;
  localparam int POLL_MS         = 500;
  ////////////////////////////////////////////////////////////////////////////
  // host registers on apb
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] CMD_OFS       = 8'h04;
  localparam logic [7:0] WDATA_OFS     = 8'h08;
  localparam logic [7:0] RDATA_OFS     = 8'h0C;
  localparam logic [7:0] STATUS_OFS    = 8'h10;
  localparam int         CTRL_GO_BIT   = 0;
  localparam int         CTRL_FORM_LSB = 1;
  localparam int         CTRL_CNT_LSB  = 3;
  localparam int         CTRL_WAIT_LSB = 8;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {pm_normal, pm_light_sleep, pm_deep_sleep_state,
                            pm_hibernate} power_mode_type;
  typedef enum logic [2:0] {k_routine, k_table, k_block, k_restore, k_store,
                            k_measure} stretch_kind_type;
  typedef enum logic [1:0] {f_write, f_read, f_quick} form_type;
  typedef enum logic [2:0] {w_none, w_sum, w_measure, w_rw, w_poll}
    wait_sel_type;

  function automatic int ms_cycles(input int ms, input int per);
    return ms * per;
  endfunction
endpackage

/* gauge_link_if.sv */
interface gauge_link_if;
  logic scl;
  logic sda;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;

  // open-drain wired and
  assign scl = !((scl_dev_oe && !scl_dev_o) || (scl_host_oe && !scl_host_o));
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));

  modport device (input scl, sda,
                  output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe);
  modport host (input scl, sda,
                output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe);
endinterface

/* gauge_host.sv */
module gauge_host
  import gauge_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  gauge_link_if.host       link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  typedef enum logic [2:0] {h_idle, h_start, h_byte, h_stop, h_wait}
    seq_type;
  typedef enum logic [2:0] {b_addrw, b_cmd, b_wdata, b_addrr, b_rdata}
    step_type;

  seq_type      hs;
  step_type     step;
  form_type     form;
  wait_sel_type wsel;
  logic [1:0]   cnt;
  logic [1:0]   idx;
  logic [7:0]   cmd_reg;
  logic [31:0]  wdata_reg;
  logic [31:0]  rdata_reg;
  logic         busy;
  logic         nack;
  logic [7:0]   rx;
  logic [3:0]   bi;
  logic [1:0]   qp;
  logic [7:0]   q_cnt;
  logic [31:0]  wait_cnt;
  logic         scl_oe;
  logic         sda_oe;
  logic         scl_m;
  logic         scl_s;
  logic         sda_m;
  logic         sda_s;

  function automatic int wait_cycles(input wait_sel_type s);
    unique case (s)
      w_sum:     return ms_cycles(WAIT_SUM_MS, CYC_PER_MS);
      w_measure: return ms_cycles(WAIT_MEASURE_MS, CYC_PER_MS);
      w_rw:      return ms_cycles(WAIT_RW_MS, CYC_PER_MS);
      w_poll:    return ms_cycles(POLL_MS, CYC_PER_MS);
      default:   return 0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire       setup    = psel_i && !penable_i;
  wire       wr_take  = psel_i && penable_i && pready_o && pwrite_i;
  wire       go       = wr_take && paddr_i == CTRL_OFS
                        && pwdata_i[CTRL_GO_BIT] && !busy;
  wire       mapped   = paddr_i <= STATUS_OFS && paddr_i[1:0] == 2'b00;
  wire [31:0] ctrl_rd = {21'h0, wsel, 3'h0, cnt, form, 1'b0};
  wire [31:0] rd_mux  = paddr_i == CTRL_OFS ? ctrl_rd
                        : paddr_i == CMD_OFS ? {24'h0, cmd_reg}
                        : paddr_i == WDATA_OFS ? wdata_reg
                        : paddr_i == RDATA_OFS ? rdata_reg
                        : paddr_i == STATUS_OFS ? {30'h0, nack, busy}
                        : 32'h0;
  wire [4:0] lane     = {idx, 3'b000};
  wire [7:0] tx_byte  = step == b_addrw ? {TARGET_ADDR, 1'b0}
                        : step == b_cmd ? cmd_reg
                        : step == b_wdata ? wdata_reg[lane +: 8]
                        : step == b_addrr ? {TARGET_ADDR, 1'b1} : 8'hFF;
  wire       last     = idx == cnt;
  wire       out_bit  = bi == 4'd8 ? (step != b_rdata || last)
                        : (step == b_rdata || tx_byte[3'd7 - bi[2:0]]);
  // quarter 2 waits out a stretch
  wire       tick     = q_cnt == 8'(QUARTER_CYC - 1) && (qp != 2'd2 || scl_s);

  assign link.scl_host_o  = 1'b0;
  assign link.sda_host_o  = 1'b0;
  assign link.scl_host_oe = scl_oe;
  assign link.sda_host_oe = sda_oe;

  always_ff @(posedge clk_sys_i)
  begin
    scl_m <= link.scl;
    sda_m <= link.sda;
    scl_s <= scl_m;
    sda_s <= sda_m;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      form      <= f_write;
      cnt       <= 2'h0;
      wsel      <= w_none;
      cmd_reg   <= 8'h00;
      wdata_reg <= 32'h0;
    end
    else
    begin
      pready_o  <= setup;
      pslverr_o <= setup && !mapped;
      prdata_o  <= (setup && !pwrite_i) ? rd_mux : 32'h0;
      if (wr_take && paddr_i == CTRL_OFS && !busy)
      begin
        form <= form_type'(pwdata_i[CTRL_FORM_LSB +: 2]);
        cnt  <= pwdata_i[CTRL_CNT_LSB +: 2];
        wsel <= wait_sel_type'(pwdata_i[CTRL_WAIT_LSB +: 3]);
      end
      if (wr_take && paddr_i == CMD_OFS && !busy)
        cmd_reg <= pwdata_i[7:0];
      if (wr_take && paddr_i == WDATA_OFS && !busy)
        wdata_reg <= pwdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link sequencer, four quarters per bit
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      hs        <= h_idle;
      step      <= b_addrw;
      idx       <= 2'h0;
      busy      <= 1'b0;
      nack      <= 1'b0;
      rdata_reg <= 32'h0;
      rx        <= 8'h00;
      bi        <= 4'h0;
      qp        <= 2'h0;
      q_cnt     <= 8'h00;
      wait_cnt  <= 32'h0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (hs == h_idle)
    begin
      if (go)
      begin
        busy      <= 1'b1;
        nack      <= 1'b0;
        rdata_reg <= 32'h0;
        idx       <= 2'h0;
        step      <= form_type'(pwdata_i[CTRL_FORM_LSB +: 2]) == f_quick
                     ? b_addrr : b_addrw;
        hs        <= h_start;
        qp        <= 2'h0;
        q_cnt     <= 8'h00;
      end
    end
    else if (hs == h_wait)
    begin
      if (wait_cnt == 32'h0)
      begin
        busy <= 1'b0;
        hs   <= h_idle;
      end
      else
        wait_cnt <= wait_cnt - 32'h1;
    end
    else if (!tick)
      q_cnt <= q_cnt + 8'h01;
    else
    begin
      q_cnt <= 8'h00;
      qp    <= qp + 2'd1;
      unique case (qp + 2'd1)
        2'd1: sda_oe <= hs == h_start ? 1'b0 : hs == h_stop ? 1'b1 : !out_bit;
        2'd2: scl_oe <= 1'b0;
        2'd3:
          if (hs == h_start)
            sda_oe <= 1'b1;
          else if (hs == h_stop)
            sda_oe <= 1'b0;
          else if (bi < 4'd8)
            rx <= {rx[6:0], sda_s};
          else if (step != b_rdata && sda_s)
            nack <= 1'b1;
        2'd0:
        begin
          scl_oe <= hs != h_stop;
          bi     <= 4'h0;
          if (hs == h_start)
            hs <= h_byte;
          else if (hs == h_stop)
          begin
            hs       <= h_wait;
            wait_cnt <= 32'(wait_cycles(wsel));
          end
          else if (bi != 4'd8)
            bi <= bi + 4'd1;
          else if (nack)
            hs <= h_stop;
          else
            unique case (step)
              b_addrw: step <= b_cmd;
              b_cmd:
                if (form == f_write)
                  step <= b_wdata;
                else
                begin
                  step <= b_addrr;
                  hs   <= h_start;
                end
              b_wdata:
                if (last)
                  hs <= h_stop;
                else
                  idx <= idx + 2'd1;
              b_addrr: step <= b_rdata;
              b_rdata:
              begin
                rdata_reg[lane +: 8] <= rx;
                if (last)
                  hs <= h_stop;
                else
                  idx <= idx + 2'd1;
              end
            endcase
        end
      endcase
    end
  end
endmodule

/* gauge_link_checker.sv */
module gauge_link_checker
  import gauge_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF,
  parameter int UNITS      = 1
)
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe,
  input wire logic scl_host_oe
);
  localparam int LOW_MAX = UNITS * TIMEOUT_UNIT_MS * CYC_PER_MS + 16;
  localparam int ST_MAX  = (MEASURE_MS + WAKE_SLOW_MS) * CYC_PER_MS + 16;
  int         low_cnt;
  int         st_cnt;
  logic [3:0] bits;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  ////////////////////////////////////////////////////////////
  // counters
  always_ff @(posedge clk_sys_i)
  begin
    low_cnt <= (reset_i || (scl && sda)) ? 0 : low_cnt + 1;
    st_cnt  <= (reset_i || !scl_dev_oe) ? 0 : st_cnt + 1;
    if (reset_i || (scl && $past(scl) && $fell(sda)))
      bits <= 4'h0;
    else if ($rose(scl) && bits != 4'hF)
      bits <= bits + 4'h1;
  end
  a_data_stable:
    assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("sda moved");
  a_quiet_address:
    assert property (bits < 4'h8 |-> !sda_dev_oe)
    else $error("address driven");
  a_start_no_stretch:
    assert property (start_s |-> !scl_dev_oe [*3])
    else $error("scl held at start");
  a_stretch_on_low:
    assert property ($rose(scl_dev_oe) |-> !$past(scl))
    else $error("stretch on high");
  a_host_clocks:
    assert property ($fell(scl) |-> scl_host_oe)
    else $error("no host fall");
  a_host_waits:
    assert property (!scl_host_oe && !scl |=> !scl_host_oe)
    else $error("host in stretch");
  a_stretch_bound:
    assert property (st_cnt <= ST_MAX)
    else $error("stretch too long");
  a_bus_release:
    assert property (low_cnt > LOW_MAX |-> !scl_dev_oe && !sda_dev_oe)
    else $error("lines kept");
endmodule

/* gauge_i2c_target_port_tb_top.sv */
module gauge_i2c_target_port_tb_top
  import gauge_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS_CYC  = 20;
  localparam int US_CYC  = 1;
  localparam int LOW_CYC = TIMEOUT_UNIT_MS * MS_CYC;
  logic             clk_sys_i, reset_i, psel, penable, pwrite, pready;
  logic             pslverr, store_busy, last_profile, bus_sleep;
  logic             bus_sleep_b, err;
  logic [7:0]       paddr, wake_setting, timeout_units, base;
  logic [31:0]      pwdata, prdata, q, st, rd, wd;
  power_mode_type   power_mode;
  stretch_kind_type store_kind;
  int               run, max_run, lim;
  int               checked = 0, miscompares = 0, seed = 32'h5F6E;
  int               caps[6] = '{ROUTINE_MS, TABLE_MS, BLOCK_MS,
                                RESTORE_MS, STORE_MS, MEASURE_MS};
  logic [7:0]       pick[2] = '{PICK_B_CODE, PICK_A_CODE};
  logic [7:0]       wake[2] = '{WAKE_FAST_SET, WAKE_SLOW_SET};
  logic [8:0]       refuse[7] = '{9'h001, {1'b1, RO_FIRST}, {1'b1, RO_LAST},
                                  9'h069, {1'b1, PROFILE_STATUS_CMD},
                                  {1'b0, CMD_LAST}, 9'h16C};
  wire              go_seen = psel && !penable && pwrite && paddr == CTRL_OFS;
  gauge_link_if u_gauge_link_if ();
  gauge_link_if u_gauge_link_if_b ();
  gauge_target #(.CYC_PER_MS(MS_CYC), .CYC_PER_US(US_CYC)) u_gauge_target (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_gauge_link_if),
    .power_mode_i(power_mode), .wake_setting_i(wake_setting),
    .store_busy_i(store_busy), .store_kind_i(store_kind),
    .timeout_units_i(timeout_units), .last_profile_o(last_profile),
    .bus_sleep_o(bus_sleep));
  gauge_target #(.CYC_PER_MS(MS_CYC), .CYC_PER_US(US_CYC)) u_gauge_target_b (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_gauge_link_if_b),
    .power_mode_i(power_mode), .wake_setting_i(wake_setting),
    .store_busy_i(store_busy), .store_kind_i(store_kind),
    .timeout_units_i(timeout_units), .last_profile_o(),
    .bus_sleep_o(bus_sleep_b));
  gauge_host #(.CYC_PER_MS(MS_CYC)) u_gauge_host (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_gauge_link_if),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  gauge_link_checker #(.CYC_PER_MS(MS_CYC), .UNITS(1)) u_gauge_link_checker (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl(u_gauge_link_if.scl),
    .sda(u_gauge_link_if.sda), .scl_dev_oe(u_gauge_link_if.scl_dev_oe),
    .sda_dev_oe(u_gauge_link_if.sda_dev_oe),
    .scl_host_oe(u_gauge_link_if.scl_host_oe));
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    run <= u_gauge_link_if.scl_dev_oe ? run + 1 : 0;
    if (go_seen)
      max_run <= 0;
    else if (run > max_run)
      max_run <= run;
  end
  function automatic logic [31:0] ctrl_word(form_type f, int n);
    return {24'h0, 3'h0, 2'(n - 1), f, 1'b1};
  endfunction
  function automatic logic near(int c);
    return max_run >= c - 4 && max_run <= c + 8;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
      @(posedge clk_sys_i);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic link_op(form_type f, logic [7:0] c, int n, logic [31:0] d);
    apb(1'b1, CMD_OFS, {24'h0, c}, q);
    apb(1'b1, WDATA_OFS, d, q);
    apb(1'b1, CTRL_OFS, ctrl_word(f, n), q);
    do
      apb(1'b0, STATUS_OFS, 32'h0, st);
    while (st[0] !== 1'b0);
    apb(1'b0, RDATA_OFS, 32'h0, rd);
  endtask
  task automatic complete_run;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(95000 * 5);
    miscompares++;
    complete_run();
  end
  initial
  begin
    reset_i = 1'b1;
    {psel, penable, pwrite, store_busy} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    power_mode = pm_normal;
    wake_setting = WAKE_FAST_SET;
    store_kind = k_routine;
    timeout_units = 8'h01;
    {u_gauge_link_if_b.scl_host_o, u_gauge_link_if_b.sda_host_o} = 2'h0;
    {u_gauge_link_if_b.scl_host_oe, u_gauge_link_if_b.sda_host_oe} = 2'h0;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    apb(1'b0, 8'h20, 32'h0, q);
    chk("slverr", 1, err);
    chk("unmapped data", 0, q);
    $display("test apb done");
    link_op(f_read, PROFILE_STATUS_CMD, 1, 32'h0);
    chk("profile reset", 0, rd[0]);
    foreach (pick[i])
    begin
      link_op(f_write, CTRL_LO_CMD, 1, {24'h0, pick[i]});
      link_op(f_read, PROFILE_STATUS_CMD, 1, 32'h0);
      chk("profile bit", pick[i][0], rd[0]);
      chk("profile pin", pick[i][0], last_profile);
    end
    $display("test profile done");
    repeat (3)
    begin
      base = 8'h40 + {3'h0, 5'($random(seed))};
      wd = $random(seed);
      link_op(f_write, base, 4, wd);
      chk("write nack", 0, st[1]);
      link_op(f_read, base, 2, 32'h0);
      chk("incr read", {16'h0, wd[15:0]}, rd);
      link_op(f_quick, 8'h00, 2, 32'h0);
      chk("quick read", {16'h0, wd[23:8]}, rd);
    end
    $display("test pointer done");
    foreach (refuse[i])
    begin
      link_op(f_write, refuse[i][7:0], 1, $random(seed));
      chk("refuse nack", refuse[i][8], st[1]);
    end
    link_op(f_read, 8'h6C, 1, 32'h0);
    chk("read nack", 1, st[1]);
    $display("test refuse done");
    store_busy <= 1'b1;
    foreach (caps[k])
    begin
      store_kind <= stretch_kind_type'(k);
      link_op(f_write, 8'h50, 1, 32'h5A);
      chk("store", 1, near(caps[k] * MS_CYC));
    end
    store_busy <= 1'b0;
    link_op(f_write, 8'h50, 1, 32'h5A);
    chk("no stretch", 0, max_run);
    chk("no sleep", 0, bus_sleep);
    $display("test stretch done");
    for (int m = 2; m < 4; m++)
      foreach (wake[j])
      begin
        power_mode   <= power_mode_type'(m);
        wake_setting <= wake[j];
        link_op(f_read, 8'h50, 1, 32'h0);
        lim = j ? WAKE_SLOW_MS * MS_CYC : WAKE_FAST_US * US_CYC;
        chk("wake stretch", 1, near(lim));
        chk("sleep data", 32'h5A, rd);
      end
    power_mode <= pm_normal;
    $display("test wake done");
    u_gauge_link_if_b.sda_host_oe <= 1'b1;
    repeat (LOW_CYC - 100) @(posedge clk_sys_i);
    u_gauge_link_if_b.sda_host_oe <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    u_gauge_link_if_b.sda_host_oe <= 1'b1;
    repeat (LOW_CYC - 100) @(posedge clk_sys_i);
    chk("early sleep", 0, bus_sleep_b);
    repeat (300) @(posedge clk_sys_i);
    chk("bus sleep", 1, bus_sleep_b);
    chk("sda freed", 0, u_gauge_link_if_b.sda_dev_oe);
    u_gauge_link_if_b.sda_host_oe <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk("sleep left", 0, bus_sleep_b);
    $display("test timeout done");
    complete_run();
  end
endmodule
